// ===== logic/rx_control_frame_filter.v
// Receiver on/off control, turnaround timing and received-frame filtering with an AXI4-Lite register slave.
// Operation
// - Receiver-on strobe sets vector bit 15 and restarts calibration, aborting activity.
// - With transmit mask option, transmit-on sets bit 14; receiver starts after transmit.
// - Nonzero vector write turns receiver on without aborting current activity.
// - Radio-off strobe clears whole vector and forces idle at once.
// - Zero vector write lets current activity finish, then goes idle.
// - Mask strobes set or clear bit 13; vector takes write, set/clear, AND, OR.
// - Receiver becomes ready 192 us after being enabled.
// - After a frame, SFD search waits 192 us only when back-to-back delay disable (config bit 1) is set.
// - SFD starts reception; length byte gives byte count; length byte and header stored.
// - Filter disabled accepts all; enabled (reset default) needs every check.
// - Reject length below minimum derived from address modes and PAN compression.
// - Frame control bits 9:7 masked with reserved mask must be zero.
// - Reject reserved address mode 1 and version above configured maximum.
// - Destination PAN and short address match local or broadcast; extended matches local.
// - Beacon needs accept bit, length 9+, no destination, source present, PAN match.
// - Data and command need accept bit, length 9+, an address; coordinator rule otherwise.
// - Acknowledgment needs its accept bit and length exactly 5.
// - Reserved types need their accept bit (reset 0) and length 9+.
// - Filtering ignores length bit 7 and may modify frame type MSB.
// - After rejection, SFD search resumes only when whole frame is received.
// - Accepted exception only when filtering enabled; not after overflow or abort.
// - SFD status rises after delimiter, falls at last byte or rejection.
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`include "rx_filter_consts.vh"
module rx_control_frame_filter
(
	input wire clk_i,
	input wire reset_i,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire sfd_detect_i,
	input wire rx_byte_valid_i,
	input wire [7:0] rx_byte_i,
	input wire rx_overflow_i,
	input wire tx_done_i,
	output reg rx_fifo_valid_o,
	output reg [7:0] rx_fifo_data_o,
	output reg tx_start_o,
	output reg tx_abort_o,
	output reg sfd_status_o,
	output reg frame_accepted_o,
	output reg rx_ready_o
);
	localparam ST_IDLE = 3'd0;
	localparam ST_CAL = 3'd1;
	localparam ST_SEARCH = 3'd2;
	localparam ST_FRAME = 3'd3;
	localparam ST_TX = 3'd4;
	localparam ST_GAP = 3'd5;
	localparam [31:0] TURN_FULL = `TURNAROUND_CYCLES;
	localparam [15:0] TURN = TURN_FULL[15:0];

	reg [15:0] en_vec_q;
	reg [31:0] filt_a_q;
	reg [31:0] filt_b_q;
	reg [31:0] cfg_q;
	reg [15:0] pan_q;
	reg [15:0] short_q;
	reg [63:0] ext_q;
	reg [2:0] exc_q;
	reg [2:0] state_q;
	reg [15:0] timer_q;
	reg [6:0] len_q;
	reg [6:0] cnt_q;
	reg [7:0] hdr_q [0:22];
	reg decided_q;
	reg rejected_q;
	reg aw_done_q;
	reg w_done_q;
	reg [5:0] aw_q;
	reg [31:0] wd_q;
	integer i;

	// Configuration fields.
	wire filt_en = filt_a_q[0];
	wire coord = filt_a_q[1];
	wire [1:0] max_ver = filt_a_q[3:2];
	wire [2:0] rsv_mask = filt_a_q[6:4];
	wire [1:0] ft_mod = filt_b_q[2:1];
	wire acc_beacon = filt_b_q[3];
	wire acc_data = filt_b_q[4];
	wire acc_ack = filt_b_q[5];
	wire acc_cmd = filt_b_q[6];
	wire acc_rsv = filt_b_q[7];
	wire tx_mask_on_tx = cfg_q[0];
	wire b2b_delay_off = cfg_q[1];

	// AXI write channel, address and data taken in either order.
	wire do_write = aw_done_q && w_done_q && !s_axi_bvalid;
	assign s_axi_awready = !aw_done_q && !s_axi_bvalid;
	assign s_axi_wready = !w_done_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	wire strobe_wr = do_write && aw_q == `ADDR_STROBE;
	wire stb_rxon = strobe_wr && wd_q[`STB_RXON];
	wire stb_rfoff = strobe_wr && wd_q[`STB_RFOFF];
	wire stb_txon = strobe_wr && wd_q[`STB_TXON];
	wire stb_mset = strobe_wr && wd_q[`STB_MASKSET];
	wire stb_mclr = strobe_wr && wd_q[`STB_MASKCLR];
	wire vec_wr = do_write && aw_q == `ADDR_ENABLE_VECTOR;
	wire upd_wr = do_write && aw_q == `ADDR_ENABLE_UPDATE;

	// Next enable vector from every update path.
	reg [15:0] vec_d;
	always @*
	begin
		vec_d = en_vec_q;
		if (vec_wr)
			vec_d = wd_q[15:0];
		if (upd_wr)
		begin
			case (wd_q[17:16])
				`OP_WRITE: vec_d = wd_q[15:0];
				`OP_AND: vec_d = en_vec_q & wd_q[15:0];
				`OP_OR: vec_d = en_vec_q | wd_q[15:0];
				`OP_SETCLR: vec_d = wd_q[18] ? (en_vec_q | wd_q[15:0]) : (en_vec_q & ~wd_q[15:0]);
				default: vec_d = en_vec_q;
			endcase
		end
		if (stb_mset)
			vec_d[`BIT_MASKBIT] = 1'b1;
		if (stb_mclr)
			vec_d[`BIT_MASKBIT] = 1'b0;
		if (stb_txon && tx_mask_on_tx)
			vec_d[`BIT_TXMASK] = 1'b1;
		if (stb_rxon)
			vec_d[`BIT_RXON] = 1'b1;
		if (stb_rfoff)
			vec_d = 16'h0000;
	end

	// Header fields with the length and frame type adjusted for filtering only.
	wire [6:0] flen = len_q;
	wire [15:0] fcf = {hdr_q[1], hdr_q[0]};
	reg ft_msb;
	always @*
	begin
		case (ft_mod)
			2'd1: ft_msb = ~fcf[2];
			2'd2: ft_msb = 1'b0;
			2'd3: ft_msb = 1'b1;
			default: ft_msb = fcf[2];
		endcase
	end
	wire [2:0] ftype = {ft_msb, fcf[1:0]};
	wire pan_comp = fcf[6];
	wire [1:0] dmode = fcf[11:10];
	wire [1:0] ver = fcf[13:12];
	wire [1:0] smode = fcf[15:14];
	wire dst_pan = dmode != 2'd0;
	wire [4:0] dlen = dmode == 2'd3 ? 5'd10 : (dmode == 2'd2 ? 5'd4 : 5'd0);
	wire [4:0] slen = smode == 2'd3 ? 5'd8 : (smode == 2'd2 ? 5'd2 : 5'd0);
	wire [4:0] span_len = (smode != 2'd0 && !(pan_comp && dst_pan)) ? 5'd2 : 5'd0;
	wire [4:0] spos = 5'd3 + dlen;
	wire [6:0] min_len = 7'd5 + {2'b00, dlen} + {2'b00, span_len} + {2'b00, slen};
	wire [4:0] need = 5'd3 + dlen + span_len;
	wire [15:0] rx_dpan = {hdr_q[4], hdr_q[3]};
	wire [15:0] rx_dshort = {hdr_q[6], hdr_q[5]};
	wire [63:0] rx_dext = {hdr_q[12], hdr_q[11], hdr_q[10], hdr_q[9], hdr_q[8], hdr_q[7], hdr_q[6], hdr_q[5]};
	wire [15:0] rx_span = pan_comp ? rx_dpan : {hdr_q[spos + 5'd1], hdr_q[spos]};

	wire hdr_ok = flen >= min_len
		&& (fcf[9:7] & rsv_mask) == 3'b000
		&& ver <= max_ver && dmode != 2'd1 && smode != 2'd1;
	wire dst_ok = (!dst_pan || rx_dpan == pan_q || rx_dpan == `BROADCAST)
		&& (dmode != 2'd2 || rx_dshort == short_q || rx_dshort == `BROADCAST)
		&& (dmode != 2'd3 || rx_dext == ext_q);
	reg type_ok;
	always @*
	begin
		case (ftype)
			3'd0: type_ok = acc_beacon && flen >= `MIN_LEN_TYPED && dmode == 2'd0
				&& smode[1] && (rx_span == pan_q || pan_q == `BROADCAST);
			3'd1, 3'd3: type_ok = (ftype == 3'd1 ? acc_data : acc_cmd) && flen >= `MIN_LEN_TYPED
				&& (dmode != 2'd0 || smode != 2'd0)
				&& (dmode != 2'd0 || (coord && rx_span == pan_q));
			3'd2: type_ok = acc_ack && flen == `MIN_LEN_FIXED;
			default: type_ok = acc_rsv && flen >= `MIN_LEN_TYPED;
		endcase
	end
	wire accept = hdr_ok && dst_ok && type_ok;
	// Verdict is known once the addressing part is in, or at the frame end for short frames.
	wire ready_to_decide = cnt_q >= {2'b00, need} || cnt_q == flen;
	wire rx_active = state_q == ST_FRAME || state_q == ST_TX;

	always @(posedge clk_i)
	begin
		if (reset_i)
		begin
			en_vec_q <= 16'h0000;
			filt_a_q <= `FILTER_A_RESET;
			filt_b_q <= `FILTER_B_RESET;
			cfg_q <= `CONFIG_RESET;
			pan_q <= 16'hffff;
			short_q <= 16'hffff;
			ext_q <= 64'h0;
			exc_q <= 3'h0;
			state_q <= ST_IDLE;
			timer_q <= 16'h0;
			len_q <= 7'h0;
			cnt_q <= 7'h0;
			decided_q <= 1'b0;
			rejected_q <= 1'b0;
			aw_done_q <= 1'b0;
			w_done_q <= 1'b0;
			aw_q <= 6'h0;
			wd_q <= 32'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'b00;
			s_axi_rdata <= 32'h0;
			rx_fifo_valid_o <= 1'b0;
			rx_fifo_data_o <= 8'h0;
			tx_start_o <= 1'b0;
			tx_abort_o <= 1'b0;
			sfd_status_o <= 1'b0;
			frame_accepted_o <= 1'b0;
			rx_ready_o <= 1'b0;
			for (i = 0; i < 23; i = i + 1)
				hdr_q[i] <= 8'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_done_q <= 1'b1;
				aw_q <= s_axi_awaddr[5:0];
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_done_q <= 1'b1;
				wd_q <= s_axi_wdata;
			end
			if (do_write)
			begin
				aw_done_q <= 1'b0;
				w_done_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= aw_q > `ADDR_STROBE || aw_q[1:0] != 2'b00 || aw_q == `ADDR_STATUS ? 2'b10 : 2'b00;
				case (aw_q)
					`ADDR_FILTER_A: filt_a_q <= wd_q & 32'h7f;
					`ADDR_FILTER_B: filt_b_q <= wd_q & 32'hff;
					`ADDR_CONFIG: cfg_q <= wd_q & 32'h3;
					`ADDR_PAN_ID: pan_q <= wd_q[15:0];
					`ADDR_SHORT_ADDR: short_q <= wd_q[15:0];
					`ADDR_EXT_LO: ext_q[31:0] <= wd_q;
					`ADDR_EXT_HI: ext_q[63:32] <= wd_q;
					default: ;
				endcase
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (s_axi_araddr[5:0])
					`ADDR_ENABLE_VECTOR: s_axi_rdata <= {16'h0, en_vec_q};
					`ADDR_FILTER_A: s_axi_rdata <= filt_a_q;
					`ADDR_FILTER_B: s_axi_rdata <= filt_b_q;
					`ADDR_CONFIG: s_axi_rdata <= cfg_q;
					`ADDR_PAN_ID: s_axi_rdata <= {16'h0, pan_q};
					`ADDR_SHORT_ADDR: s_axi_rdata <= {16'h0, short_q};
					`ADDR_EXT_LO: s_axi_rdata <= ext_q[31:0];
					`ADDR_EXT_HI: s_axi_rdata <= ext_q[63:32];
					`ADDR_STATUS: s_axi_rdata <= {24'h0, rx_ready_o, state_q, sfd_status_o, exc_q};
					default:
					begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;

			en_vec_q <= vec_d;
			tx_start_o <= stb_txon;
			tx_abort_o <= (stb_rxon || stb_rfoff) && state_q == ST_TX;
			rx_fifo_valid_o <= 1'b0;
			frame_accepted_o <= 1'b0;
			if (timer_q != 16'h0)
				timer_q <= timer_q - 16'h1;
			// The exception sets below come later, so a coincident event wins over the clear.
			if (do_write && aw_q == `ADDR_EXC_CLEAR)
				exc_q <= exc_q & ~wd_q[2:0];

			case (state_q)
				ST_IDLE:
				begin
					if (vec_d != 16'h0000)
					begin
						state_q <= ST_CAL;
						timer_q <= TURN - 16'h1;
					end
				end
				ST_CAL, ST_GAP:
				begin
					if (vec_d == 16'h0000)
					begin
						state_q <= ST_IDLE;
						rx_ready_o <= 1'b0;
					end
					else if (timer_q == 16'h0)
					begin
						state_q <= ST_SEARCH;
						rx_ready_o <= 1'b1;
					end
				end
				ST_SEARCH:
				begin
					if (vec_d == 16'h0000)
					begin
						state_q <= ST_IDLE;
						rx_ready_o <= 1'b0;
					end
					else if (sfd_detect_i)
					begin
						state_q <= ST_FRAME;
						sfd_status_o <= 1'b1;
						exc_q[0] <= 1'b1;
						len_q <= 7'h0;
						cnt_q <= 7'h0;
						decided_q <= 1'b0;
						rejected_q <= 1'b0;
					end
				end
				ST_FRAME:
				begin
					if (rx_byte_valid_i)
					begin
						// Every byte after the delimiter, length byte included, goes to the FIFO.
						rx_fifo_valid_o <= 1'b1;
						rx_fifo_data_o <= rx_byte_i;
						if (len_q == 7'h0 && cnt_q == 7'h0 && !decided_q && !rejected_q && sfd_status_o)
						begin
							len_q <= rx_byte_i[6:0];
							decided_q <= rx_byte_i[6:0] == 7'h0;
						end
						else
						begin
							if (cnt_q < 7'd23)
								hdr_q[cnt_q[4:0]] <= rx_byte_i;
							cnt_q <= cnt_q + 7'h1;
						end
					end
					if (rx_overflow_i && !decided_q)
					begin
						decided_q <= 1'b1;
						exc_q[2] <= 1'b1;
					end
					else if (!decided_q && len_q != 7'h0 && ready_to_decide)
					begin
						decided_q <= 1'b1;
						if (filt_en && accept)
						begin
							frame_accepted_o <= 1'b1;
							exc_q[1] <= 1'b1;
						end
						else if (filt_en)
						begin
							rejected_q <= 1'b1;
							sfd_status_o <= 1'b0;
						end
					end
					if (len_q != 7'h0 && cnt_q == len_q)
					begin
						sfd_status_o <= 1'b0;
						if (vec_d == 16'h0000)
						begin
							state_q <= ST_IDLE;
							rx_ready_o <= 1'b0;
						end
						else
						begin
							state_q <= b2b_delay_off ? ST_GAP : ST_SEARCH;
							timer_q <= TURN - 16'h1;
						end
					end
				end
				ST_TX:
				begin
					if (tx_done_i)
					begin
						state_q <= vec_d != 16'h0000 ? ST_CAL : ST_IDLE;
						timer_q <= TURN - 16'h1;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
			if (stb_txon && !rx_active)
			begin
				state_q <= ST_TX;
				rx_ready_o <= 1'b0;
			end
			if (stb_rxon)
			begin
				state_q <= ST_CAL;
				timer_q <= TURN - 16'h1;
				rx_ready_o <= 1'b0;
				sfd_status_o <= 1'b0;
			end
			if (stb_rfoff)
			begin
				state_q <= ST_IDLE;
				rx_ready_o <= 1'b0;
				sfd_status_o <= 1'b0;
			end
		end
	end
endmodule

// ===== logic/rx_filter_consts.vh
// Constants for the receiver control and frame filter block.
`ifndef RX_FILTER_CONSTS_VH
`define RX_FILTER_CONSTS_VH
`define ADDR_ENABLE_VECTOR 6'h00
`define ADDR_ENABLE_UPDATE 6'h04
`define ADDR_FILTER_A 6'h08
`define ADDR_FILTER_B 6'h0c
`define ADDR_CONFIG 6'h10
`define ADDR_PAN_ID 6'h14
`define ADDR_SHORT_ADDR 6'h18
`define ADDR_EXT_LO 6'h1c
`define ADDR_EXT_HI 6'h20
`define ADDR_STATUS 6'h24
`define ADDR_EXC_CLEAR 6'h28
`define ADDR_STROBE 6'h2c
`define OP_WRITE 2'h0
`define OP_AND 2'h1
`define OP_OR 2'h2
`define OP_SETCLR 2'h3
`define BIT_RXON 15
`define BIT_TXMASK 14
`define BIT_MASKBIT 13
`define STB_RXON 0
`define STB_RFOFF 1
`define STB_TXON 2
`define STB_MASKSET 3
`define STB_MASKCLR 4
`define FILTER_A_RESET 32'h0000_000d
`define FILTER_B_RESET 32'h0000_0078
`define CONFIG_RESET 32'h0000_0002
`define TURNAROUND_NS 192000
`define CLK_PERIOD_NS 4
`define TURNAROUND_CYCLES ((`TURNAROUND_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_LEN_FIXED 7'h05
`define MIN_LEN_TYPED 7'h09
`define BROADCAST 16'hffff
`endif

// ===== testbench/rx_control_frame_filter_tb.sv
// Testbench for the receiver control and frame filter block.
`include "rx_filter_consts.vh"
`define chk(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module rx_control_frame_filter_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, reset_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sfd_detect_i, rx_byte_valid_i, tx_done_i;
	logic rx_fifo_valid_o, tx_start_o, sfd_status_o, frame_accepted_o, rx_ready_o, rx_overflow_i, tx_abort_o;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] rx_byte_i, rx_fifo_data_o, fifo_first;
	int err_total, comparisons, cyc, acc_cnt, fifo_cnt, sfd_seen, tx_cnt, abort_cnt, ovf_at;
	rx_control_frame_filter rx_control_frame_filter_i (.clk_i, .reset_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.sfd_detect_i, .rx_byte_valid_i, .rx_byte_i, .rx_overflow_i, .tx_done_i, .rx_fifo_valid_o,
		.rx_fifo_data_o, .tx_start_o, .tx_abort_o, .sfd_status_o, .frame_accepted_o, .rx_ready_o);
	rx_radio_model rx_radio_model_i (.clk_i, .tx_start_i(tx_start_o), .sfd_detect_o(sfd_detect_i),
		.rx_byte_valid_o(rx_byte_valid_i), .rx_byte_o(rx_byte_i), .tx_done_o(tx_done_i));
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cyc++;
		acc_cnt += frame_accepted_o;
		if (rx_fifo_valid_o && fifo_cnt == 0)
			fifo_first = rx_fifo_data_o;
		fifo_cnt += rx_fifo_valid_o;
		sfd_seen |= sfd_status_o;
		tx_cnt += tx_start_o;
		abort_cnt += tx_abort_o;
		if (cyc == 60000)
		begin
			err_total++;
			final_report();
		end
	end
	task final_report;
		if (err_total == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task axi_wr(input [5:0] a, input [31:0] d, input [1:0] er);
		@(posedge clk_i);
		s_axi_awaddr <= {26'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk_i);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		`chk(s_axi_bresp, er)
	endtask
	task axi_rd(input [5:0] a, input [31:0] m, input [31:0] e, input [1:0] er);
		@(posedge clk_i);
		s_axi_araddr <= {26'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk_i);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		`chk(s_axi_rdata & m, e)
		`chk(s_axi_rresp, er)
	endtask
	task t_regs;
		axi_rd(`ADDR_FILTER_A, 32'hffff_ffff, `FILTER_A_RESET, 2'h0);
		axi_rd(`ADDR_FILTER_B, 32'hffff_ffff, `FILTER_B_RESET, 2'h0);
		axi_rd(`ADDR_SHORT_ADDR, 32'h0000_ffff, 32'h0000_ffff, 2'h0);
		axi_rd(6'h3c, 32'hffff_ffff, 32'h0, 2'h2);
		axi_wr(`ADDR_STATUS, 32'h0, 2'h2);
		axi_wr(`ADDR_PAN_ID, 32'h0000_ffff, 2'h0);
		axi_rd(`ADDR_CONFIG, 32'hffff_ffff, `CONFIG_RESET, 2'h0);
		axi_wr(`ADDR_CONFIG, 32'h0, 2'h0);
	endtask
	task t_vector;
		axi_wr(`ADDR_ENABLE_VECTOR, 32'h0000_0003, 2'h0);
		axi_rd(`ADDR_STATUS, 32'h0000_0070, 32'h0000_0010, 2'h0);
		axi_wr(`ADDR_ENABLE_UPDATE, {13'h0, 1'b0, `OP_OR, 16'h0100}, 2'h0);
		axi_wr(`ADDR_ENABLE_UPDATE, {13'h0, 1'b0, `OP_AND, 16'h0102}, 2'h0);
		axi_wr(`ADDR_ENABLE_UPDATE, {13'h0, 1'b1, `OP_SETCLR, 16'h0008}, 2'h0);
		axi_wr(`ADDR_ENABLE_UPDATE, {13'h0, 1'b0, `OP_SETCLR, 16'h0100}, 2'h0);
		axi_rd(`ADDR_ENABLE_VECTOR, 32'h0000_ffff, 32'h0000_000a, 2'h0);
		axi_wr(`ADDR_STROBE, 32'h1 << `STB_MASKSET, 2'h0);
		axi_rd(`ADDR_ENABLE_VECTOR, 32'h0000_ffff, 32'h0000_200a, 2'h0);
		axi_wr(`ADDR_STROBE, 32'h1 << `STB_MASKCLR, 2'h0);
		axi_wr(`ADDR_STROBE, 32'h1 << `STB_RXON, 2'h0);
		axi_rd(`ADDR_ENABLE_VECTOR, 32'h0000_ffff, 32'h0000_800a, 2'h0);
		axi_wr(`ADDR_STROBE, 32'h1 << `STB_RFOFF, 2'h0);
		axi_rd(`ADDR_ENABLE_VECTOR, 32'h0000_ffff, 32'h0, 2'h0);
		axi_rd(`ADDR_STATUS, 32'h0000_00f0, 32'h0, 2'h0);
	endtask
	task t_turn;
		int n;
		axi_wr(`ADDR_STROBE, 32'h1 << `STB_RXON, 2'h0);
		n = 0;
		while (rx_ready_o !== 1'b1)
		begin
			@(posedge clk_i);
			n++;
		end
		`chk(n >= `TURNAROUND_CYCLES - 4 && n <= `TURNAROUND_CYCLES + 4, 1'b1)
		axi_rd(`ADDR_STATUS, 32'h0000_00f0, 32'h0000_00a0, 2'h0);
	endtask
	task frame_case(input [7:0] len, input [15:0] fcf, input [15:0] pan, input [15:0] adr, input int exp);
		int n, i;
		n = len[6:0] + 1;
		for (i = 0; i < n; i++)
			rx_radio_model_i.frm[i] = 8'h00;
		{rx_radio_model_i.frm[0], rx_radio_model_i.frm[1], rx_radio_model_i.frm[2]} = {len, fcf[7:0], fcf[15:8]};
		{rx_radio_model_i.frm[4], rx_radio_model_i.frm[5]} = {pan[7:0], pan[15:8]};
		{rx_radio_model_i.frm[6], rx_radio_model_i.frm[7]} = {adr[7:0], adr[15:8]};
		@(negedge clk_i);
		acc_cnt = 0;
		fifo_cnt = 0;
		sfd_seen = 0;
		fork
			rx_radio_model_i.send_frame(n);
			if (ovf_at > 0)
			begin
				repeat (ovf_at) @(posedge clk_i);
				rx_overflow_i <= 1'b1;
				@(posedge clk_i);
				rx_overflow_i <= 1'b0;
			end
		join
		repeat (8) @(posedge clk_i);
		`chk(acc_cnt, exp)
		`chk(sfd_status_o, 1'b0)
		`chk(sfd_seen, 1)
		if (exp == 1)
		begin
			`chk(fifo_cnt, n)
			`chk(fifo_first, len)
		end
	endtask
	task t_frames;
		frame_case(8'h05, 16'h0002, 16'h0000, 16'h0000, 1);
		frame_case(8'h06, 16'h0002, 16'h0000, 16'h0000, 0);
		frame_case(8'h85, 16'h0002, 16'h0000, 16'h0000, 1);
		frame_case(8'h09, 16'h0801, 16'hffff, 16'hffff, 1);
		frame_case(8'h09, 16'h0801, 16'hffff, 16'h1234, 0);
		frame_case(8'h08, 16'h0801, 16'hffff, 16'hffff, 0);
		frame_case(8'h09, 16'h0401, 16'hffff, 16'hffff, 0);
		frame_case(8'h09, 16'h0004, 16'hffff, 16'hffff, 0);
		frame_case(8'h09, 16'h8000, 16'h1234, 16'h0001, 1);
		ovf_at = 4;
		frame_case(8'h05, 16'h0002, 16'h0000, 16'h0000, 0);
		ovf_at = 0;
		axi_rd(`ADDR_STATUS, 32'h0000_0007, 32'h0000_0007, 2'h0);
		axi_wr(`ADDR_EXC_CLEAR, 32'h0000_0007, 2'h0);
		axi_rd(`ADDR_STATUS, 32'h0000_0007, 32'h0, 2'h0);
		axi_wr(`ADDR_FILTER_A, 32'h0000_001d, 2'h0);
		frame_case(8'h05, 16'h0082, 16'h0000, 16'h0000, 0);
		axi_wr(`ADDR_FILTER_A, 32'h0000_000c, 2'h0);
		frame_case(8'h08, 16'h0801, 16'hffff, 16'hffff, 0);
		axi_wr(`ADDR_CONFIG, 32'h0000_0002, 2'h0);
		frame_case(8'h05, 16'h0002, 16'h0000, 16'h0000, 0);
		axi_rd(`ADDR_STATUS, 32'h0000_0070, 32'h0000_0050, 2'h0);
	endtask
	task t_tx;
		axi_wr(`ADDR_STROBE, 32'h1 << `STB_RFOFF, 2'h0);
		`chk(rx_ready_o, 1'b0)
		axi_wr(`ADDR_CONFIG, 32'h0000_0001, 2'h0);
		axi_wr(`ADDR_STROBE, 32'h1 << `STB_TXON, 2'h0);
		axi_rd(`ADDR_ENABLE_VECTOR, 32'h0000_ffff, 32'h0000_4000, 2'h0);
		`chk(tx_cnt, 1)
		repeat (30) @(posedge clk_i);
		axi_rd(`ADDR_STATUS, 32'h0000_0070, 32'h0000_0010, 2'h0);
		axi_wr(`ADDR_ENABLE_VECTOR, 32'h0, 2'h0);
		axi_rd(`ADDR_STATUS, 32'h0000_0070, 32'h0, 2'h0);
		axi_wr(`ADDR_STROBE, 32'h1 << `STB_TXON, 2'h0);
		axi_wr(`ADDR_STROBE, 32'h1 << `STB_RFOFF, 2'h0);
		axi_rd(`ADDR_STATUS, 32'h0000_0070, 32'h0, 2'h0);
		`chk(abort_cnt, 1)
	endtask
	initial
	begin
		{reset_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rx_overflow_i} = 7'b1000000;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		repeat (3) @(posedge clk_i);
		reset_i <= 1'b0;
		t_regs();
		t_vector();
		t_turn();
		t_frames();
		t_tx();
		final_report();
	end
endmodule

// ===== testbench/rx_filter_asserts.sv
// Concurrent checks on the ports of the receiver control and frame filter block.
module rx_filter_asserts
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sfd_detect_i,
	input wire logic rx_byte_valid_i,
	input wire logic rx_fifo_valid_o,
	input wire logic sfd_status_o,
	input wire logic frame_accepted_o,
	input wire logic tx_start_o,
	input wire logic rx_ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int min_low = 47990;
	logic [15:0] low_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// Counts the cycles that the receiver has been not ready.
	always @(posedge clk_i)
	begin
		if (reset_i || rx_ready_o)
			low_q <= 16'h0000;
		else if (low_q != 16'hffff)
			low_q <= low_q + 16'h0001;
	end
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
	aw_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("awready while pending");
	ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready while pending");
	sfd_rise_a: assert property ($rose(sfd_status_o) |-> $past(sfd_detect_i, 1) || $past(sfd_detect_i, 2))
		else $error("sfd status rose without delimiter");
	fifo_source_a: assert property (rx_fifo_valid_o |-> $past(rx_byte_valid_i, 1) || $past(rx_byte_valid_i, 2))
		else $error("fifo byte without received byte");
	accept_pulse_a: assert property (frame_accepted_o |=> !frame_accepted_o) else $error("accept not a pulse");
	tx_pulse_a: assert property (tx_start_o |=> !tx_start_o) else $error("tx start not a pulse");
	ready_turn_a: assert property ($rose(rx_ready_o) |-> low_q >= min_low) else $error("ready too early");
endmodule
bind rx_control_frame_filter rx_filter_asserts rx_filter_asserts_i (.clk_i, .reset_i, .s_axi_awready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .sfd_detect_i, .rx_byte_valid_i, .rx_fifo_valid_o,
	.sfd_status_o, .frame_accepted_o, .tx_start_o, .rx_ready_o);

// ===== testbench/rx_radio_model.sv
// Radio-side model that delivers received frames and finishes transmissions.
module rx_radio_model
(
	input wire logic clk_i,
	input wire logic tx_start_i,
	output logic sfd_detect_o,
	output logic rx_byte_valid_o,
	output logic [7:0] rx_byte_o,
	output logic tx_done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] frm [0:127];
	logic [4:0] tx_cnt_q;
	initial
	begin
		sfd_detect_o = 1'b0;
		rx_byte_valid_o = 1'b0;
		rx_byte_o = 8'h00;
		tx_done_o = 1'b0;
		tx_cnt_q = 5'h00;
	end
	// Delimiter first, then the length byte and the rest, one byte every two cycles.
	task send_frame(input int n);
		int i;
		begin
			@(posedge clk_i);
			sfd_detect_o <= 1'b1;
			@(posedge clk_i);
			sfd_detect_o <= 1'b0;
			for (i = 0; i < n; i++)
			begin
				@(posedge clk_i);
				rx_byte_valid_o <= 1'b1;
				rx_byte_o <= frm[i];
				@(posedge clk_i);
				rx_byte_valid_o <= 1'b0;
				rx_byte_o <= ~frm[i];
			end
		end
	endtask
	// A transmission ends twenty cycles after it starts.
	always @(posedge clk_i)
	begin
		if (tx_start_i)
			tx_cnt_q <= 5'h14;
		else if (tx_cnt_q != 5'h00)
			tx_cnt_q <= tx_cnt_q - 5'h01;
		tx_done_o <= (tx_cnt_q == 5'h01);
	end
endmodule
